// file: design/amas_defs.svh
`ifndef AMAS_DEFS_SVH
`define AMAS_DEFS_SVH
// Clock and timing
`define AMAS_CLK_MHZ 10
`define AMAS_SETTLE_NS 3000
`define AMAS_HOLD_NS 2000
`define AMAS_SETTLE_CYC ((`AMAS_SETTLE_NS * `AMAS_CLK_MHZ + 999) / 1000)
`define AMAS_HOLD_CYC ((`AMAS_HOLD_NS * `AMAS_CLK_MHZ + 999) / 1000)
// Register byte offsets
`define AMAS_OFS_CTRL 6'h00
`define AMAS_OFS_STATUS 6'h04
`define AMAS_OFS_AVG 6'h08
`define AMAS_OFS_TOTAL 6'h0C
`define AMAS_OFS_PTR 6'h10
`define AMAS_OFS_RESULT 6'h14
`define AMAS_OFS_TABLE 6'h20
// Control fields
`define AMAS_CTRL_RUN 0
`define AMAS_CTRL_INIT 1
// Status fields
`define AMAS_STAT_CARRY 8
// Data table layout
`define AMAS_TBL_BASE 16'h0000
`define AMAS_TBL_STEP 16'h0002
`define AMAS_TBL_LAST 16'h0010
// Sequencer status values
`define AMAS_SEQ_IDLE 8'h00
`define AMAS_SEQ_RUN 8'h01
// Shift count for divide by 8
`define AMAS_SHIFTS 2'h3
`endif

// file: design/amas_pkg.sv
package amas_pkg;

  typedef enum logic [4:0] {
    AMAS_IDLE,
    AMAS_CLR_TIMER,
    AMAS_SET_EN,
    AMAS_WAIT_SETTLE,
    AMAS_CLR_DONE,
    AMAS_SET_START,
    AMAS_WAIT_HOLD,
    AMAS_POLL_DONE,
    AMAS_CLR_DONE2,
    AMAS_READ_RESULT,
    AMAS_DISABLE,
    AMAS_FETCH_OLD,
    AMAS_SUB_OLD,
    AMAS_ADD_NEW,
    AMAS_COPY_TOTAL,
    AMAS_SHIFT,
    AMAS_STORE_AVG,
    AMAS_STORE_TABLE,
    AMAS_ADVANCE,
    AMAS_COMPARE,
    AMAS_BRANCH,
    AMAS_RELOAD,
    AMAS_TERMINATE
  } amas_state_t;

  typedef struct packed {
    amas_state_t st;
    logic [7:0] seq_status;
    logic carry;
    logic [7:0] wait_cnt;
    logic [1:0] shift_cnt;
    logic [15:0] result;
    logic [15:0] oldest;
    logic [15:0] total;
    logic [15:0] scratch;
    logic [15:0] average;
    logic [15:0] ptr;
    logic [7:0][15:0] tbl;
    logic enable;
    logic conv_en;
    logic conv_start;
    logic done_clr;
    logic timer_clr;
    logic ack;
    logic [31:0] rdata;
  } amas_state_s_t;

endpackage

// file: design/amas_top.sv
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "amas_defs.svh"
// Functional notes
// - Each timer event starts one averaging run while the CTRL run bit is set
// - Clear timer flag, enable converter, wait 3us
// - Clear done, start, wait 2us, poll done
// - Clear done again, read 16-bit result
// - Disable converter after reading result
// - Total holds sum of last 8 results
// - Fetch oldest sample at table pointer first
// - Subtract oldest then add newest to total
// - Copy total, shift right three times
// - Store average every run
// - Overwrite oldest table entry with newest
// - Advance pointer by one word step
// - Borrow on compare goes straight to termination
// - No borrow reloads pointer, then terminates
// - Termination stops until next trigger
// - Termination clears sequencer status to 00H
// - Shift inserts 0 at bit 15, bit0 to carry
// - Subtract and compare set carry on borrow
module amas_top (
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic [5:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic TIMER_FLAG_IN,
  output logic TIMER_FLAG_CLR_OUT,
  output logic CONV_ENABLE_OUT,
  output logic CONV_START_OUT,
  input wire logic CONV_DONE_IN,
  output logic CONV_DONE_CLR_OUT,
  input wire logic [15:0] CONV_RESULT_IN,
  output logic [15:0] AVERAGE_OUT,
  output logic BUSY_OUT
);
  import amas_pkg::*;

  amas_state_s_t s;
  amas_state_s_t n;
  logic req;
  logic init_req;
  logic [2:0] tbl_idx;
  logic [31:0] rd_mux;
  logic [16:0] diff;
  logic [16:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and read mux

  assign req = AVS_READ_IN | AVS_WRITE_IN;
  assign AVS_WAITREQUEST_OUT = req & ~s.ack;
  assign tbl_idx = s.ptr[3:1];

  always_comb begin
    rd_mux = 32'h00000000;
    if (AVS_ADDRESS_IN[5]) begin
      rd_mux = {16'h0000, s.tbl[AVS_ADDRESS_IN[4:2]]};
    end else begin
      case (AVS_ADDRESS_IN)
        `AMAS_OFS_CTRL: rd_mux = {31'h00000000, s.enable};
        `AMAS_OFS_STATUS: rd_mux = {23'h000000, s.carry, s.seq_status};
        `AMAS_OFS_AVG: rd_mux = {16'h0000, s.average};
        `AMAS_OFS_TOTAL: rd_mux = {16'h0000, s.total};
        `AMAS_OFS_PTR: rd_mux = {16'h0000, s.ptr};
        `AMAS_OFS_RESULT: rd_mux = {16'h0000, s.result};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = s;
    n.timer_clr = 1'b0;
    n.done_clr = 1'b0;
    init_req = 1'b0;
    diff = 17'h00000;
    sum = 17'h00000;
    n.ack = req & ~s.ack;
    if (AVS_READ_IN & ~s.ack) begin
      n.rdata = rd_mux;
    end
    if (AVS_WRITE_IN & s.ack & (AVS_ADDRESS_IN == `AMAS_OFS_CTRL)
        & AVS_BYTEENABLE_IN[0]) begin
      n.enable = AVS_WRITEDATA_IN[`AMAS_CTRL_RUN];
      init_req = AVS_WRITEDATA_IN[`AMAS_CTRL_INIT];
    end
    case (s.st)
      AMAS_IDLE: begin
        if (init_req) begin
          n.ptr = `AMAS_TBL_BASE;
          n.total = 16'h0000;
          n.tbl = '0;
        end else if (s.enable & TIMER_FLAG_IN) begin
          n.seq_status = `AMAS_SEQ_RUN;
          n.st = AMAS_CLR_TIMER;
        end
      end
      AMAS_CLR_TIMER: begin
        n.timer_clr = 1'b1;
        n.st = AMAS_SET_EN;
      end
      AMAS_SET_EN: begin
        n.conv_en = 1'b1;
        n.wait_cnt = 8'(`AMAS_SETTLE_CYC - 1);
        n.st = AMAS_WAIT_SETTLE;
      end
      AMAS_WAIT_SETTLE: begin
        if (s.wait_cnt == 8'h00) begin
          n.st = AMAS_CLR_DONE;
        end else begin
          n.wait_cnt = s.wait_cnt - 8'h01;
        end
      end
      AMAS_CLR_DONE: begin
        n.done_clr = 1'b1;
        n.st = AMAS_SET_START;
      end
      AMAS_SET_START: begin
        n.conv_start = 1'b1;
        n.wait_cnt = 8'(`AMAS_HOLD_CYC - 1);
        n.st = AMAS_WAIT_HOLD;
      end
      AMAS_WAIT_HOLD: begin
        if (s.wait_cnt == 8'h00) begin
          n.st = AMAS_POLL_DONE;
        end else begin
          n.wait_cnt = s.wait_cnt - 8'h01;
        end
      end
      AMAS_POLL_DONE: begin
        if (CONV_DONE_IN) begin
          n.conv_start = 1'b0;
          n.st = AMAS_CLR_DONE2;
        end
      end
      AMAS_CLR_DONE2: begin
        n.done_clr = 1'b1;
        n.st = AMAS_READ_RESULT;
      end
      AMAS_READ_RESULT: begin
        n.result = CONV_RESULT_IN;
        n.st = AMAS_DISABLE;
      end
      AMAS_DISABLE: begin
        n.conv_en = 1'b0;
        n.st = AMAS_FETCH_OLD;
      end
      AMAS_FETCH_OLD: begin
        n.oldest = s.tbl[tbl_idx];
        n.st = AMAS_SUB_OLD;
      end
      AMAS_SUB_OLD: begin
        diff = {1'b0, s.total} - {1'b0, s.oldest};
        n.total = diff[15:0];
        n.carry = diff[16];
        n.st = AMAS_ADD_NEW;
      end
      AMAS_ADD_NEW: begin
        sum = {1'b0, s.total} + {1'b0, s.result};
        n.total = sum[15:0];
        n.carry = sum[16];
        n.st = AMAS_COPY_TOTAL;
      end
      AMAS_COPY_TOTAL: begin
        n.scratch = s.total;
        n.shift_cnt = `AMAS_SHIFTS;
        n.st = AMAS_SHIFT;
      end
      AMAS_SHIFT: begin
        n.scratch = {1'b0, s.scratch[15:1]};
        n.carry = s.scratch[0];
        n.shift_cnt = s.shift_cnt - 2'h1;
        if (s.shift_cnt == 2'h1) begin
          n.st = AMAS_STORE_AVG;
        end
      end
      AMAS_STORE_AVG: begin
        n.average = s.scratch;
        n.st = AMAS_STORE_TABLE;
      end
      AMAS_STORE_TABLE: begin
        n.tbl[tbl_idx] = s.result;
        n.st = AMAS_ADVANCE;
      end
      AMAS_ADVANCE: begin
        sum = {1'b0, s.ptr} + {1'b0, `AMAS_TBL_STEP};
        n.ptr = sum[15:0];
        n.carry = sum[16];
        n.st = AMAS_COMPARE;
      end
      AMAS_COMPARE: begin
        diff = {1'b0, s.ptr} - {1'b0, `AMAS_TBL_LAST};
        n.carry = diff[16];
        n.st = AMAS_BRANCH;
      end
      AMAS_BRANCH: begin
        if (s.carry) begin
          n.st = AMAS_TERMINATE;
        end else begin
          n.st = AMAS_RELOAD;
        end
      end
      AMAS_RELOAD: begin
        n.ptr = `AMAS_TBL_BASE;
        n.st = AMAS_TERMINATE;
      end
      AMAS_TERMINATE: begin
        n.seq_status = `AMAS_SEQ_IDLE;
        n.st = AMAS_IDLE;
      end
      default: begin
        n.st = AMAS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign AVS_READDATA_OUT = s.rdata;
  assign TIMER_FLAG_CLR_OUT = s.timer_clr;
  assign CONV_ENABLE_OUT = s.conv_en;
  assign CONV_START_OUT = s.conv_start;
  assign CONV_DONE_CLR_OUT = s.done_clr;
  assign AVERAGE_OUT = s.average;
  assign BUSY_OUT = s.seq_status[0];

endmodule

// file: tb/amas_assertions.sv
`timescale 1ns/100ps
module amas_assertions (
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic TIMER_FLAG_CLR_OUT,
  input wire logic CONV_ENABLE_OUT,
  input wire logic CONV_START_OUT,
  input wire logic CONV_DONE_CLR_OUT,
  input wire logic BUSY_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  a_trig_clear: assert property ($rose(BUSY_OUT) |-> ##[0:1] TIMER_FLAG_CLR_OUT)
    else $error("timer flag not cleared");
  a_en_settle: assert property ($rose(CONV_START_OUT) |-> $past(CONV_ENABLE_OUT, 30))
    else $error("start before settle");
  a_start_en: assert property (CONV_START_OUT |-> CONV_ENABLE_OUT)
    else $error("start without enable");
  a_start_hold: assert property ($fell(CONV_START_OUT) |-> $past(CONV_START_OUT, 20))
    else $error("start hold short");
  a_done_clr: assert property ($fell(CONV_START_OUT) |-> ##[0:1] CONV_DONE_CLR_OUT)
    else $error("done not cleared");
  a_conv_off: assert property ($fell(CONV_START_OUT) |-> ##[1:3] $fell(CONV_ENABLE_OUT))
    else $error("converter left on");
  a_run_end: assert property ($fell(CONV_ENABLE_OUT) |-> ##[8:20] $fell(BUSY_OUT))
    else $error("run not ended");
  a_idle_quiet: assert property (!BUSY_OUT |-> !CONV_ENABLE_OUT && !CONV_START_OUT)
    else $error("converter active when idle");
  cover property ($fell(BUSY_OUT));
  cover property ($rose(CONV_START_OUT));
  cover property ($fell(CONV_ENABLE_OUT));
endmodule
bind amas_top amas_assertions u_chk (.*);

// file: tb/amas_conv_model.sv
`timescale 1ns/100ps
module amas_conv_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [7:0] lat,
  input wire logic [15:0] samp,
  input wire logic tclr,
  input wire logic en,
  input wire logic start,
  input wire logic dclr,
  output logic tflag,
  output logic done,
  output logic [15:0] res
);
  logic [7:0] cnt;
  // Result invalid while converter off
  assign res = en ? samp : ~samp;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tflag <= 1'h0;
      done <= 1'h0;
      cnt <= 8'h00;
    end else begin
      if (fire) tflag <= 1'h1;
      else if (tclr) tflag <= 1'h0;
      cnt <= start ? cnt + 8'h01 : 8'h00;
      if (dclr) done <= 1'h0;
      else if (start && cnt == lat) done <= 1'h1;
    end
  end
endmodule

// file: tb/amas_top_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, (e), (g)); end end
module amas_top_tb;
  logic clk, rst_n, rd, wr, wreq, tflag, tclr, en, st, done, dclr, busy, fire;
  logic [5:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [15:0] res, avg, samp, e_tot, e_ptr;
  logic [15:0] e_tbl [8];
  logic [7:0] lat;
  int errors, n_tests;
  amas_top dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
    .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
    .TIMER_FLAG_IN(tflag), .TIMER_FLAG_CLR_OUT(tclr), .CONV_ENABLE_OUT(en),
    .CONV_START_OUT(st), .CONV_DONE_IN(done), .CONV_DONE_CLR_OUT(dclr),
    .CONV_RESULT_IN(res), .AVERAGE_OUT(avg), .BUSY_OUT(busy));
  amas_conv_model u_conv (.clk(clk), .rst_n(rst_n), .fire(fire), .lat(lat),
    .samp(samp), .tclr(tclr), .en(en), .start(st), .dclr(dclr), .tflag(tflag),
    .done(done), .res(res));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task results;
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int i;
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wreq !== 1'h0 && i < 20);
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk);
    if (i >= 20) begin
      errors++;
      results;
    end
  endtask
  task rdchk(input logic [5:0] a, input logic [31:0] e, input string n);
    bus(1'h0, a, 32'h0);
    `CHK(n, e, q)
  endtask
  task fire_run(input logic [15:0] s, input logic [7:0] l);
    samp <= s;
    lat <= l;
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
  endtask
  task finish_run(input logic [15:0] s);
    int i;
    logic c;
    logic [2:0] x;
    i = 0;
    while (busy !== 1'h1 && i < 20) begin
      @(posedge clk);
      i++;
    end
    if (i >= 20) begin
      errors++;
      results;
    end
    while (busy !== 1'h0 && i < 500) begin
      @(posedge clk);
      i++;
    end
    if (i >= 500) begin
      errors++;
      results;
    end
    x = e_ptr[3:1];
    e_tot = e_tot - e_tbl[x] + s;
    e_tbl[x] = s;
    e_ptr = e_ptr + 16'h0002;
    c = e_ptr < 16'h0010;
    if (!c) e_ptr = 16'h0000;
    `CHK("average", e_tot >> 3, avg)
    rdchk(6'h0C, {16'h0, e_tot}, "total");
    rdchk(6'h10, {16'h0, e_ptr}, "pointer");
    rdchk(6'h04, {23'h0, c, 8'h00}, "status");
    rdchk({1'h1, x, 2'h0}, {16'h0, s}, "table");
  endtask
  task t_reset;
    bus(1'h1, 6'h10, 32'h0000000E);
    rdchk(6'h10, 32'h0, "pointer reset");
    rdchk(6'h0C, 32'h0, "total reset");
    rdchk(6'h18, 32'h0, "unmapped");
    rdchk(6'h04, 32'h0, "status reset");
  endtask
  task t_gate;
    fire_run(16'h0F0F, 8'h00);
    repeat (10) @(posedge clk);
    `CHK("gated busy", 1'h0, busy)
    bus(1'h1, 6'h00, 32'h1);
    finish_run(16'h0F0F);
  endtask
  task t_runs;
    logic [15:0] v;
    for (int k = 1; k < 10; k++) begin
      v = 16'h3A57 * k[15:0];
      fire_run(v, k[0] ? 8'h28 : 8'h00);
      finish_run(v);
    end
  endtask
  task t_midreset;
    fire_run(16'h1234, 8'h05);
    repeat (40) @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    `CHK("busy in reset", 1'h0, busy)
    `CHK("enable in reset", 1'h0, en)
    rst_n <= 1'h1;
    @(posedge clk);
    `CHK("busy after reset", 1'h0, busy)
    rdchk(6'h0C, 32'h0, "total mid reset");
    rdchk(6'h10, 32'h0, "pointer mid reset");
    e_tot = 16'h0;
    e_ptr = 16'h0;
    e_tbl = '{default: 16'h0};
  endtask
  task t_init;
    bus(1'h1, 6'h00, 32'h3);
    e_tot = 16'h0;
    e_ptr = 16'h0;
    e_tbl = '{default: 16'h0};
    rdchk(6'h10, 32'h0, "pointer init");
    rdchk(6'h0C, 32'h0, "total init");
    fire_run(16'hFFFF, 8'h05);
    finish_run(16'hFFFF);
  endtask
  initial begin
    rst_n = 1'h0;
    adr = 6'h00;
    rd = 1'h0;
    wr = 1'h0;
    wdat = 32'h0;
    fire = 1'h0;
    lat = 8'h00;
    samp = 16'h0;
    errors = 0;
    n_tests = 0;
    e_tot = 16'h0;
    e_ptr = 16'h0;
    e_tbl = '{default: 16'h0};
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset;
    t_gate;
    t_runs;
    t_midreset;
    t_init;
    results;
  end
endmodule
